// ===== spdc_host.sv
// Debug host model: pin pull-down, reset pin and byte stream
`timescale 1ns/1ns
module spdc_host (
  // Clock
  input wire clk_i,
  // Link
  output reg pull_low_o = 1'b0,
  output reg rst_pin_n_o = 1'b1,
  output reg rx_valid_o = 1'b0,
  output reg [7:0] rx_byte_o = 8'h00
);
  task send(input [7:0] b);
    begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o <= b;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~b;
    end
  endtask
  task break_opcode(input integer n);
    begin
      @(posedge clk_i);
      pull_low_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      pull_low_o <= 1'b0;
    end
  endtask
  task unlock(input integer w, input [7:0] k);
    begin
      @(posedge clk_i);
      rst_pin_n_o <= 1'b0;
      repeat (w) @(posedge clk_i);
      send(8'h80);
      send(8'heb);
      send(k);
      send(8'h70);
      send(8'hcd);
    end
  endtask
  task release_rst;
    begin
      @(posedge clk_i);
      rst_pin_n_o <= 1'b1;
    end
  endtask
endmodule // spdc_host

// ===== spdc_monitor.sv
// Checker of the single-pin debug controller
`timescale 1ns/1ns
module spdc_monitor #(
  parameter BREAK_CYC = 32'd4096
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // Pins and CPU
  input wire debug_pin_i,
  input wire rx_valid_i,
  input wire [7:0] rx_byte_i,
  input wire cpu_opc_valid_i,
  input wire [7:0] cpu_opc_i,
  input wire flash_read_protect_i,
  input wire cpu_fetch_stop_o,
  input wire cpu_illegal_o,
  input wire dev_reset_o,
  input wire ocd_reset_o,
  input wire pin_is_debug_o
);
  reg [31:0] low_cnt;
  reg [5:0] dev_cnt;
  wire key_end;
  wire ill_op;
  assign key_end = rx_valid_i && rx_byte_i == 8'hcd;
  assign ill_op = cpu_opc_valid_i && cpu_opc_i == 8'hff;
  always @(posedge clk_i) begin
    low_cnt <= debug_pin_i ? 32'd0 : low_cnt + 32'd1;
    dev_cnt <= dev_reset_o ? dev_cnt + 6'd1 : 6'd0;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wr_mode_zero;
    wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] &&
      !wb_dat_i[7] && !wb_dat_i[0];
  endsequence
  sequence stays_stopped;
    cpu_fetch_stop_o [*3];
  endsequence
  a_ack_one_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
  a_illegal_flag: assert property (
    cpu_illegal_o == $past(ill_op)) else $error("illegal flag wrong");
  a_break_holds: assert property (
    low_cnt >= BREAK_CYC + 12 |-> ocd_reset_o)
    else $error("break without debug reset");
  a_break_ends: assert property (
    debug_pin_i [*8] |-> !ocd_reset_o) else $error("debug reset stuck");
  a_unlock_key: assert property (
    $rose(pin_is_debug_o) |-> $past(key_end) || $past(key_end, 2))
    else $error("pin freed without key");
  a_reset_length: assert property (
    $fell(dev_reset_o) |-> dev_cnt >= 6'd15 && dev_cnt <= 6'd17)
    else $error("device reset length wrong");
  a_protect_hold: assert property (
    flash_read_protect_i && cpu_fetch_stop_o ##0 wr_mode_zero
      |=> stays_stopped) else $error("protected mode cleared");
  a_break_keeps_mode: assert property (
    cpu_fetch_stop_o && ocd_reset_o && !dev_reset_o |=> cpu_fetch_stop_o)
    else $error("break left debug mode");
endmodule // spdc_monitor

bind spdc_top spdc_monitor #(.BREAK_CYC(BREAK_CYC)) u_mon (.*);

// ===== spdc_regs.vh
// Register map, field positions and timing counts of the debug controller
`ifndef SPDC_REGS_VH
`define SPDC_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define SPDC_ADDR_CTRL 8'h00
`define SPDC_ADDR_STAT 8'h04
`define SPDC_ADDR_OPC 8'h08

// ****************************************************************
// Debugger control register fields
// ****************************************************************
`define SPDC_BIT_MODE 7
`define SPDC_BIT_BREAKPOINT_ENABLE_BIT 6
`define SPDC_BIT_ACK 5
`define SPDC_BIT_RST 0
`define SPDC_CTRL_RESET 8'h00
`define SPDC_CTRL_WMASK 8'he1

// ****************************************************************
// Opcodes and serial bytes
// ****************************************************************
`define SPDC_OPC_BREAK 8'h00
`define SPDC_OPC_ILLEGAL 8'hff
`define SPDC_BYTE_AUTOBAUD 8'h80
`define SPDC_KEY0 8'heb
`define SPDC_KEY1 8'h5a
`define SPDC_KEY2 8'h70
`define SPDC_KEY3 8'hcd
`define SPDC_CMD_EXEC 8'h12

// ****************************************************************
// Timing
// ****************************************************************
`define SPDC_CLK_HZ 20000000
`define SPDC_RST_WAIT_US 5000
`define SPDC_RST_WAIT_CYC (`SPDC_CLK_HZ / 1000000 * `SPDC_RST_WAIT_US)
`define SPDC_DEV_RST_CYC 8'h10

`endif

// ===== spdc_sync.v
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ns
module spdc_sync #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Data
  input wire d_i,
  output reg q_o
);
  reg meta_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // spdc_sync

// ===== spdc_top.v
// Single-pin debug controller: break detect, unlock, control register
// Notes on behaviour
// R1 - A serial break never clears debug mode once the device is in it.
// R2 - The debug unit is held in reset while the pin is low in a break.
// R3 - Being open drain, a host break is seen even while we transmit.
// R4 - On the small package an unfinished unlock leaves the pin as GPIO.
// R5 - The host holds reset low and waits 5 ms before sending.
// R6 - The host sends 80h then EBh 5Ah 70h CDh during reset.
// R7 - After reset release the host reautobauds and writes 80h to control.
// R8 - A decoded break opcode with breakpoints on sets debug mode.
// R9 - 81h resets and stops, 41h resets and runs, 40h resumes.
// R10 - The CPU stops fetching while debug mode is set.
// R11 - With read protection on, debug mode clears only on device reset.
// R12 - Breakpoints are off after reset; the break opcode then is a nop.
// R13 - A refused execute command reads and discards one byte.
// R14 - Erased memory reads FFh, which the CPU flags as illegal.
// R15 - The device reset bit starts a reset and clears when it is done.
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "spdc_regs.vh"
module spdc_top #(
  parameter RST_WAIT_CYC = `SPDC_RST_WAIT_CYC,
  parameter BREAK_CYC = 32'd4096,
  parameter SMALL_PKG = 1'b1
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Debug pin, open drain
  input wire debug_pin_i,
  output reg debug_pin_o,
  output reg debug_pin_oe_o,
  // Serial byte stream from the debug receiver
  input wire rx_valid_i,
  input wire [7:0] rx_byte_i,
  input wire tx_drive_low_i,
  // Shared reset pin, active low
  input wire shared_reset_pin_n_i,
  // CPU side
  input wire cpu_opc_valid_i,
  input wire [7:0] cpu_opc_i,
  input wire flash_read_protect_i,
  output reg cpu_fetch_stop_o,
  output reg cpu_illegal_o,
  output reg dev_reset_o,
  output reg ocd_reset_o,
  output reg pin_is_debug_o,
  output reg rx_discard_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  wire pin_s;
  wire rstn_s;

  spdc_sync #(.RESET_VAL(1'b1)) u_sync_pin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(debug_pin_i),
    .q_o(pin_s)
  );

  spdc_sync #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(shared_reset_pin_n_i),
    .q_o(rstn_s)
  );

  // ****************************************************************
  // Serial break detection
  // ****************************************************************
  reg [31:0] low_cnt_reg;
  reg break_reg;

  // R3 - pin level seen regardless of drive
  always @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_reg <= 32'h0;
      break_reg <= 1'b0;
    end else if (pin_s) begin
      low_cnt_reg <= 32'h0;
      break_reg <= 1'b0;
    end else begin
      if (low_cnt_reg < BREAK_CYC)
        low_cnt_reg <= low_cnt_reg + 32'h1;
      else
        break_reg <= 1'b1;
    end
  end

  // R2 - unit held in reset for the break
  always @(posedge clk_i) begin
    if (rst_i)
      ocd_reset_o <= 1'b1;
    else
      ocd_reset_o <= break_reg;
  end

  // ****************************************************************
  // Unlock sequence while the shared reset pin is low
  // ****************************************************************
  localparam U_WAIT = 6'b000001;
  localparam U_AB = 6'b000010;
  localparam U_K0 = 6'b000100;
  localparam U_K1 = 6'b001000;
  localparam U_K2 = 6'b010000;
  localparam U_K3 = 6'b100000;

  reg [5:0] ust_reg;
  reg [31:0] wait_cnt_reg;
  reg unlocked_reg;
  reg rstn_d_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ust_reg <= U_WAIT;
      wait_cnt_reg <= 32'h0;
      unlocked_reg <= 1'b0;
      rstn_d_reg <= 1'b1;
    end else begin
      rstn_d_reg <= rstn_s;
      if (rstn_s) begin
        ust_reg <= U_WAIT;
        wait_cnt_reg <= 32'h0;
      end else if (rstn_d_reg) begin
        // R4 - new reset: relock until key seen
        unlocked_reg <= 1'b0;
        ust_reg <= U_WAIT;
        wait_cnt_reg <= 32'h0;
      end else begin
        case (ust_reg)
          U_WAIT: begin
            // R5 - host waits out internal reset
            if (wait_cnt_reg < RST_WAIT_CYC)
              wait_cnt_reg <= wait_cnt_reg + 32'h1;
            else
              ust_reg <= U_AB;
          end
          // R6 - autobaud then key bytes in order
          U_AB: if (rx_valid_i)
            ust_reg <= (rx_byte_i == `SPDC_BYTE_AUTOBAUD) ? U_K0 : U_AB;
          U_K0: if (rx_valid_i)
            ust_reg <= (rx_byte_i == `SPDC_KEY0) ? U_K1 : U_AB;
          U_K1: if (rx_valid_i)
            ust_reg <= (rx_byte_i == `SPDC_KEY1) ? U_K2 : U_AB;
          U_K2: if (rx_valid_i)
            ust_reg <= (rx_byte_i == `SPDC_KEY2) ? U_K3 : U_AB;
          U_K3: if (rx_valid_i) begin
            ust_reg <= U_AB;
            if (rx_byte_i == `SPDC_KEY3)
              unlocked_reg <= 1'b1;
          end
          default: ust_reg <= U_WAIT;
        endcase
      end
    end
  end

  // ****************************************************************
  // Control register and device reset
  // ****************************************************************
  reg [7:0] ctrl_reg;
  reg [7:0] rst_cnt_reg;
  reg stop_after_reg;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] &
    (wb_adr_i == `SPDC_ADDR_CTRL);
  wire [7:0] wd = wb_dat_i[7:0];
  wire brk_hit = cpu_opc_valid_i & (cpu_opc_i == `SPDC_OPC_BREAK);

  always @(posedge clk_i) begin
    if (rst_i) begin
      // R12 - breakpoints off after reset
      ctrl_reg <= `SPDC_CTRL_RESET;
      rst_cnt_reg <= 8'h0;
      stop_after_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[`SPDC_BIT_BREAKPOINT_ENABLE_BIT] <= wd[`SPDC_BIT_BREAKPOINT_ENABLE_BIT];
        ctrl_reg[`SPDC_BIT_ACK] <= wd[`SPDC_BIT_ACK];
        // R11 - zero write ignored under protection
        if (wd[`SPDC_BIT_MODE] | ~flash_read_protect_i)
          ctrl_reg[`SPDC_BIT_MODE] <= wd[`SPDC_BIT_MODE];
        // R9 R15 - reset bit starts device reset
        if (wd[`SPDC_BIT_RST]) begin
          ctrl_reg[`SPDC_BIT_RST] <= 1'b1;
          rst_cnt_reg <= `SPDC_DEV_RST_CYC;
          stop_after_reg <= wd[`SPDC_BIT_MODE];
        end
      end
      // R8 R12 - break opcode only with breakpoints on
      if (brk_hit & ctrl_reg[`SPDC_BIT_BREAKPOINT_ENABLE_BIT])
        ctrl_reg[`SPDC_BIT_MODE] <= 1'b1;
      // R15 - self clearing device reset
      if (rst_cnt_reg != 8'h0) begin
        rst_cnt_reg <= rst_cnt_reg - 8'h1;
        if (rst_cnt_reg == 8'h1) begin
          ctrl_reg[`SPDC_BIT_RST] <= 1'b0;
          // R11 R9 - reset clears mode unless stop asked
          ctrl_reg[`SPDC_BIT_MODE] <= stop_after_reg;
        end
      end
      // R1 - break leaves mode bit untouched
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dev_reset_o <= 1'b0;
      cpu_fetch_stop_o <= 1'b0;
    end else begin
      dev_reset_o <= rst_cnt_reg != 8'h0;
      // R10 - fetch halted in debug mode
      cpu_fetch_stop_o <= ctrl_reg[`SPDC_BIT_MODE];
    end
  end

  // ****************************************************************
  // Execute command refusal and pin ownership
  // ****************************************************************
  reg exec_hdr_reg;

  always @(posedge clk_i) begin
    if (rst_i | ocd_reset_o) begin
      exec_hdr_reg <= 1'b0;
      rx_discard_o <= 1'b0;
    end else begin
      rx_discard_o <= 1'b0;
      if (rx_valid_i) begin
        // R13 - refused command drops one byte
        if (exec_hdr_reg) begin
          exec_hdr_reg <= 1'b0;
          rx_discard_o <= ~ctrl_reg[`SPDC_BIT_MODE] | flash_read_protect_i;
        end else if (rx_byte_i == `SPDC_CMD_EXEC)
          exec_hdr_reg <= 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_is_debug_o <= ~SMALL_PKG;
      debug_pin_o <= 1'b0;
      debug_pin_oe_o <= 1'b0;
      cpu_illegal_o <= 1'b0;
    end else begin
      // R4 - GPIO only until unlocked
      pin_is_debug_o <= ~SMALL_PKG | unlocked_reg;
      debug_pin_o <= 1'b0;
      // R3 - only ever pull low
      debug_pin_oe_o <= tx_drive_low_i & (~SMALL_PKG | unlocked_reg) &
        ~break_reg;
      // R14 - erased byte flagged illegal
      cpu_illegal_o <= cpu_opc_valid_i & (cpu_opc_i == `SPDC_OPC_ILLEGAL);
    end
  end

  // ****************************************************************
  // Wishbone slave, one wait state
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `SPDC_ADDR_CTRL: wb_dat_o <= {24'h0, ctrl_reg};
          `SPDC_ADDR_STAT: wb_dat_o <= {28'h0, unlocked_reg, break_reg,
            ~ocd_reset_o, rst_cnt_reg != 8'h0};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule // spdc_top

// ===== tb_spdc_top.sv
// Testbench of the single-pin debug controller
`timescale 1ns/1ns
`include "spdc_regs.vh"
module tb_spdc_top;
  localparam RW = 50;
  localparam BC = 16;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hf;
  reg [31:0] wb_dat_i = 32'h0;
  reg tx_drive_low_i = 1'b0;
  reg cpu_opc_valid_i = 1'b0;
  reg [7:0] cpu_opc_i = 8'h00;
  reg flash_read_protect_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire [7:0] rx_byte_i;
  wire wb_ack_o, debug_pin_oe_o, pull_low, shared_reset_pin_n_i;
  wire rx_valid_i, cpu_fetch_stop_o, cpu_illegal_o, dev_reset_o;
  wire ocd_reset_o, pin_is_debug_o, rx_discard_o;
  wire debug_pin_i = ~(pull_low | debug_pin_oe_o);
  integer n_fail = 0;
  integer samples_checked = 0;
  integer seed = 1;
  integer mode = 0;
  integer breakpoint_enable_bit = 0;
  integer n_disc = 0;
  integer i;
  reg [7:0] q;
  reg [7:0] b;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (rx_discard_o) n_disc <= n_disc + 1;
  spdc_top #(.RST_WAIT_CYC(RW), .BREAK_CYC(BC)) dut (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .debug_pin_i, .debug_pin_o(), .debug_pin_oe_o,
    .rx_valid_i, .rx_byte_i, .tx_drive_low_i, .shared_reset_pin_n_i,
    .cpu_opc_valid_i, .cpu_opc_i, .flash_read_protect_i, .cpu_fetch_stop_o,
    .cpu_illegal_o, .dev_reset_o, .ocd_reset_o, .pin_is_debug_o,
    .rx_discard_o);
  spdc_host host (.clk_i, .pull_low_o(pull_low),
    .rst_pin_n_o(shared_reset_pin_n_i), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i));
  task finish_test;
    begin
      if (n_fail == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [7:0] d);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task ctrl_wr(input [7:0] d);
    begin
      wb(1'b1, `SPDC_ADDR_CTRL, d);
      if (d[0] || !(flash_read_protect_i && mode != 0 && !d[7]))
        mode = d[7];
      breakpoint_enable_bit = d[6];
      repeat (24) @(posedge clk_i);
      chk("fetch_stop", mode[7:0], {7'h0, cpu_fetch_stop_o});
      wb(1'b0, `SPDC_ADDR_CTRL, 8'h00);
      chk("ctrl", {mode[0], breakpoint_enable_bit[0], 6'h0}, q & 8'hc1);
    end
  endtask
  task op(input [7:0] o);
    begin
      cpu_opc_valid_i <= 1'b1;
      cpu_opc_i <= o;
      @(posedge clk_i);
      cpu_opc_valid_i <= 1'b0;
      cpu_opc_i <= ~o;
      @(posedge clk_i);
      chk("illegal", {7'h0, o == 8'hff}, {7'h0, cpu_illegal_o});
      repeat (2) @(posedge clk_i);
      if (o == 8'h00 && breakpoint_enable_bit != 0) mode = 1;
      chk("fetch_stop", mode[7:0], {7'h0, cpu_fetch_stop_o});
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `SPDC_ADDR_CTRL, 8'h00);
    chk("ctrl_rst", 8'h00, q);
    wb(1'b1, `SPDC_ADDR_OPC, 8'h5a);
    wb(1'b0, `SPDC_ADDR_OPC, 8'h00);
    chk("unmapped", 8'h00, q);
    host.unlock(RW + 5, 8'h00);
    repeat (4) @(posedge clk_i);
    chk("pin_debug", 8'h00, {7'h0, pin_is_debug_o});
    host.unlock(RW + 5, 8'h5a);
    repeat (3) @(posedge clk_i);
    chk("pin_debug", 8'h01, {7'h0, pin_is_debug_o});
    host.release_rst;
    wb(1'b0, `SPDC_ADDR_STAT, 8'h00);
    chk("status", 8'h0a, q);
    host.send(`SPDC_BYTE_AUTOBAUD);
    ctrl_wr(8'h80);
    ctrl_wr(8'h00);
    op(8'h00);
    ctrl_wr(8'h40);
    op(8'h00);
    tx_drive_low_i <= 1'b1;
    fork
      host.break_opcode(BC + 24);
      begin
        repeat (BC + 18) @(posedge clk_i);
        chk("ocd_reset", 8'h01, {7'h0, ocd_reset_o});
      end
    join
    tx_drive_low_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("ocd_reset", 8'h00, {7'h0, ocd_reset_o});
    chk("fetch_stop", 8'h01, {7'h0, cpu_fetch_stop_o});
    ctrl_wr(8'h40);
    op(8'h00);
    flash_read_protect_i <= 1'b1;
    @(posedge clk_i);
    ctrl_wr(8'h40);
    ctrl_wr(8'h81);
    ctrl_wr(8'h41);
    flash_read_protect_i <= 1'b0;
    for (i = 0; i < 24; i = i + 1) begin
      b = $random(seed);
      op((i % 4 == 0) ? 8'hff : b | 8'h01);
    end
    host.send(`SPDC_CMD_EXEC);
    host.send(8'h3c);
    repeat (4) @(posedge clk_i);
    chk("discard", 8'h01, n_disc[7:0]);
    finish_test;
  end
  initial begin
    #(50 * 20000);
    n_fail = n_fail + 1;
    finish_test;
  end
endmodule // tb_spdc_top
